//--- design/tsa_consts.vh
// constants for the two-step converter pipeline and its word buffer
// assumes inclusion by bare name from design files only
`ifndef TSA_CONSTS_VH
`define TSA_CONSTS_VH

`define TSA_WORD_W 8
`define TSA_NIB_W 4
`define TSA_FULL_CODE 8'hFF
`define TSA_NIB_ZERO 4'h0
`define TSA_WORD_ZERO 8'h00
`define TSA_BANKS 2
`define TSA_FIFO_DEPTH 16
`define TSA_FIFO_AW 4
`define TSA_CONV_FREQ_HZ 50000000

`endif

//--- design/tsa_fifo.v
// synchronous word buffer with valid/ready on both sides
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module tsa_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire arst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire full,
   output wire empty
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire do_wr;
   wire do_rd;

   // extra pointer bit tells full from empty
   assign empty = (wr_ptr == rd_ptr);
   assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                 (wr_ptr[AW] != rd_ptr[AW]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign do_wr = in_valid & ~full;
   assign do_rd = out_ready & ~empty;

   always @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

endmodule // tsa_fifo

`default_nettype wire

//--- design/tsa_top.v
// two-step converter timing model: sample, coarse, fine, merge, output
// assumes conv_clk, analog_step and output_enable_n arrive from pins
//
// Overview of operation
// - upper bank plus two four-bit lower banks
// - sample on each conversion clock falling edge
// - first rise fixes upper nibble, fine reference
// - second rise fixes lower nibble in bank
// - third rise merges nibbles onto output bus
// - output follows sampling edge by 2.5 clocks
// - consecutive samples alternate lower banks
// - fully pipelined, one word per rising edge
// - code equals 255 minus step
// - drive bus while enable low, else float
`timescale 1ns/1ps
`default_nettype none
`include "tsa_consts.vh"

module tsa_top (
   input wire clk,
   input wire arst_n,
   input wire conv_clk,
   input wire [`TSA_WORD_W-1:0] analog_step,
   input wire output_enable_n,
   output wire [`TSA_WORD_W-1:0] sample_data_bus_out,
   output wire sample_data_bus_oe,
   output wire word_valid,
   output wire [`TSA_WORD_W-1:0] stream_data,
   output wire stream_valid,
   input wire stream_ready,
   output wire stream_room
);

   // pin synchronisers; first stages feed only second stages
   reg conv_s1;
   reg conv_s2;
   reg conv_prev;
   reg [`TSA_WORD_W-1:0] step_s1;
   reg [`TSA_WORD_W-1:0] step_s2;
   reg oe_n_s1;
   reg oe_n_s2;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_s1 <= 1'b0;
         conv_s2 <= 1'b0;
         conv_prev <= 1'b0;
         step_s1 <= `TSA_WORD_ZERO;
         step_s2 <= `TSA_WORD_ZERO;
         oe_n_s1 <= 1'b1;
         oe_n_s2 <= 1'b1;
      end else begin
         conv_s1 <= conv_clk;
         conv_s2 <= conv_s1;
         conv_prev <= conv_s2;
         step_s1 <= analog_step;
         step_s2 <= step_s1;
         oe_n_s1 <= output_enable_n;
         oe_n_s2 <= oe_n_s1;
      end
   end

   wire conv_fall;
   wire conv_rise;
   assign conv_fall = conv_prev & ~conv_s2;
   assign conv_rise = ~conv_prev & conv_s2;

   // stage 0: held sample and its bank
   reg sel_bank;
   reg s0_valid;
   reg s0_bank;
   reg [`TSA_WORD_W-1:0] s0_step;
   // stage 1: coarse result
   reg s1_valid;
   reg s1_bank;
   reg [`TSA_NIB_W-1:0] upper_nibble;
   reg [`TSA_WORD_W-1:0] fine_reference_level;
   // stage 2: fine result
   reg s2_valid;
   reg s2_bank;
   reg [`TSA_NIB_W-1:0] s2_upper;
   wire [`TSA_NIB_W-1:0] lower_nibble;
   // output word
   reg out_valid;
   reg [`TSA_WORD_W-1:0] out_word;
   reg push;

   // per-bank sample hold and fine result
   reg [`TSA_WORD_W-1:0] bank_step [0:`TSA_BANKS-1];
   reg [`TSA_NIB_W-1:0] bank_lower [0:`TSA_BANKS-1];

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_bank <= 1'b0;
         s0_valid <= 1'b0;
         s0_bank <= 1'b0;
         s0_step <= `TSA_WORD_ZERO;
      end else if (conv_fall) begin
         s0_valid <= 1'b1;
         s0_step <= step_s2;
         s0_bank <= sel_bank;
         sel_bank <= ~sel_bank;
      end
   end

   genvar b;
   generate
      for (b = 0; b < `TSA_BANKS; b = b + 1) begin : g_bank
         wire [`TSA_WORD_W-1:0] code;
         wire [`TSA_WORD_W-1:0] resid;
         // residue against the coarse level picks out the low nibble
         assign code = `TSA_FULL_CODE - bank_step[b];
         assign resid = code - fine_reference_level;
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               bank_step[b] <= `TSA_WORD_ZERO;
               bank_lower[b] <= `TSA_NIB_ZERO;
            end else begin
               if (conv_fall && (sel_bank == b)) begin
                  bank_step[b] <= step_s2;
               end
               if (conv_rise && s1_valid && (s1_bank == b)) begin
                  bank_lower[b] <= resid[`TSA_NIB_W-1:0];
               end
            end
         end
      end
   endgenerate

   wire [`TSA_WORD_W-1:0] s0_code;
   assign s0_code = `TSA_FULL_CODE - s0_step;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_valid <= 1'b0;
         s1_bank <= 1'b0;
         upper_nibble <= `TSA_NIB_ZERO;
         fine_reference_level <= `TSA_WORD_ZERO;
         s2_valid <= 1'b0;
         s2_bank <= 1'b0;
         s2_upper <= `TSA_NIB_ZERO;
         out_valid <= 1'b0;
         out_word <= `TSA_WORD_ZERO;
      end else if (conv_rise) begin
         // every rise advances stage 1, stage 2 and the output word at once; stage 0 moves on the fall
         s1_valid <= s0_valid;
         s1_bank <= s0_bank;
         upper_nibble <= s0_code[`TSA_WORD_W-1:`TSA_NIB_W];
         fine_reference_level <= {s0_code[`TSA_WORD_W-1:`TSA_NIB_W],
                                  `TSA_NIB_ZERO};
         s2_valid <= s1_valid;
         s2_upper <= upper_nibble;
         s2_bank <= s1_bank;
         out_valid <= s2_valid;
         out_word <= {s2_upper, lower_nibble};
      end
   end

   // one push per new output word; full buffer drops the word
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         push <= 1'b0;
      end else begin
         push <= conv_rise & s2_valid;
      end
   end

   // bank result holds until that bank's next sample, two rises on
   assign lower_nibble = s2_bank ? bank_lower[1] : bank_lower[0];
   assign sample_data_bus_out = out_word;
   assign sample_data_bus_oe = ~oe_n_s2;
   assign word_valid = out_valid;

   tsa_fifo #(
      .WIDTH(`TSA_WORD_W),
      .DEPTH(`TSA_FIFO_DEPTH),
      .AW(`TSA_FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(push),
      .in_ready(stream_room),
      .in_data(out_word),
      .out_valid(stream_valid),
      .out_ready(stream_ready),
      .out_data(stream_data),
      .full(),
      .empty()
   );

endmodule // tsa_top

`default_nettype wire

//--- testbench/tsa_capture.sv
// capture model: latches the shared bus once per conversion clock
// assumes the word settles well before each conversion clock fall
`timescale 1ns/1ps
`default_nettype none
module tsa_capture (
   input wire logic conv_clk,
   input wire logic [7:0] bus,
   output logic [7:0] word
);
   // fall is two and a half clocks clear of the word change
   always @(negedge conv_clk) word <= bus;
endmodule // tsa_capture
`default_nettype wire

//--- testbench/tsa_properties.sv
// checker: pin timing of the converter pipeline
// assumes binding onto tsa_top, one clock
`timescale 1ns/1ps
`default_nettype none
module tsa_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic conv_clk,
   input wire logic output_enable_n,
   input wire logic [7:0] sample_data_bus_out,
   input wire logic sample_data_bus_oe,
   input wire logic word_valid,
   input wire logic stream_valid,
   input wire logic stream_room
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   oe_on_a: assert property ($fell(output_enable_n) |->
      ##[1:3] sample_data_bus_oe) else $error("enable late");
   oe_off_a: assert property ($rose(output_enable_n) |->
      ##[1:3] !sample_data_bus_oe) else $error("float late");
   word_hold_a: assert property ($changed(sample_data_bus_out) |=>
      $stable(sample_data_bus_out)[*2]) else $error("word unstable");
   change_rise_a: assert property ($changed(sample_data_bus_out) |->
      $past(conv_clk, 3)) else $error("word off rise");
   valid_stays_a: assert property (word_valid |=> word_valid)
      else $error("valid dropped");
   first_word_a: assert property ($rose(word_valid) |->
      $past(conv_clk, 3)) else $error("valid off rise");
   no_early_a: assert property (!word_valid |-> !stream_valid)
      else $error("stale push");
   full_head_a: assert property (!stream_room |-> stream_valid)
      else $error("full but empty");
endmodule // tsa_checker
bind tsa_top tsa_checker chk_u (.clk, .arst_n, .conv_clk, .output_enable_n,
   .sample_data_bus_out, .sample_data_bus_oe, .word_valid, .stream_valid,
   .stream_room);
`default_nettype wire

//--- testbench/two_step_adc_output_pipeline_bench.sv
// bench: pipeline, word buffer and bus enable of tsa_top
// assumes a 50 MHz clk and a slow conversion clock
`timescale 1ns/1ps
`default_nettype none
module two_step_adc_output_pipeline_bench;
   logic clk = 0, arst_n = 0, conv_clk = 1, oe_n = 0, rdy = 0;
   logic [7:0] step = 0;
   logic [7:0] code [20];
   logic [7:0] es [4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};
   wire logic [7:0] out, sd, cap;
   wire logic oe, wv, sv, room;
   wire logic [7:0] bus = oe ? out : 8'hZZ;
   int num_errors = 0, n_compared = 0;
   tsa_top dut (.clk(clk), .arst_n(arst_n), .conv_clk(conv_clk),
      .analog_step(step), .output_enable_n(oe_n),
      .sample_data_bus_out(out), .sample_data_bus_oe(oe), .word_valid(wv),
      .stream_data(sd), .stream_valid(sv), .stream_ready(rdy),
      .stream_room(room));
   tsa_capture cap_m (.conv_clk(conv_clk), .bus(bus), .word(cap));
   initial forever #10 clk = ~clk;
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      n_compared++;
      if (a !== e) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, a, e);
      end
   endtask
   // step held a whole period so the sample point never races it
   task automatic t_pipe;
      for (int j = 0; j < 20; j++) begin
         step = j < 4 ? es[j] : 8'(j * 7 + 3);
         code[j] = 8'hFF - step;
         conv_clk = 1;
         cyc(5);
         conv_clk = 0;
         cyc(5);
         if (j >= 3) begin
            chk(out, code[j-3]);
            chk(cap, code[j-3]);
            chk({7'h00, wv}, 8'h01);
         end
      end
   endtask
   // conv_clk stands still so no push races the drain
   task automatic t_fifo;
      chk({6'h00, sv, room}, 8'h02);
      rdy = 1;
      for (int k = 0; k < 16; k++) begin
         chk(sd, code[k]);
         cyc(1);
      end
      rdy = 0;
      chk({6'h00, sv, room}, 8'h01);
   endtask
   task automatic t_oe;
      oe_n = 1;
      cyc(4);
      chk(bus, 8'hZZ);
      oe_n = 0;
      cyc(4);
      chk(bus, code[16]);
   endtask
   task automatic tally_and_finish;
      if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      cyc(5);
      arst_n = 1;
      cyc(2);
      t_pipe;
      t_fifo;
      t_oe;
      tally_and_finish;
   end
   initial begin
      #20000;
      num_errors++;
      tally_and_finish;
   end
endmodule // two_step_adc_output_pipeline_bench
`default_nettype wire
